// File: src/increment_skip_instr_exec.sv
// executor for increment, increment-skip and unconditional branch instructions
// assumes file register read data is valid by Q3 and writes are taken at Q4
// assumes instr and file_rdata come from logic on this same clock
// Function
// - increment opcode adds one to file register
// - dest bit: 0 working_reg, 1 file
// - decode increment-skip-if-nonzero opcode
// - skip when nonzero result for that opcode
// - skip discards prefetch, runs nop cycle
// - skip-nonzero takes one or two cycles
// - skip instructions leave status unchanged
// - increment-skip-if-zero skips on zero result
// - branch loads pc, then full nop cycle
`timescale 1ns/1ps
module increment_skip_instr_exec (
  input  wire logic        clk,          // instruction clock source, 10 MHz
  input  wire logic        srst,         // synchronous reset, active high
  input  wire logic [15:0] instr,        // prefetched instruction word
  input  wire logic [7:0]  file_rdata,   // addressed file register contents
  output logic      [7:0]  file_addr,    // file register address
  output logic      [7:0]  file_wdata,   // file register write data
  output logic             file_we,      // file register write strobe
  output logic      [7:0]  working_reg,  // working register
  output logic      [3:0]  status,       // {overflow, zero, digit carry, carry}
  output logic      [15:0] pc,           // program counter
  output logic      [1:0]  qphase,       // current sub-phase
  output logic             nop_cycle,    // current cycle is a forced nop
  output logic             instr_done    // pulse at last Q4 of an instruction
);
  incr_exec_pkg::qphase_t q;
  logic [15:0] ir;
  logic        dead;        // forced nop cycle active
  logic        next_dead;
  logic [6:0]  opc;
  logic        is_incr;
  logic        is_skz;
  logic        is_sknz;
  logic        is_br;
  logic        dest_file;
  logic        skip_now;
  incr_alu_if  alu_bus ();

  incr_alu u_alu (
    .port_a (alu_bus)
  );

  // ==================================================
  // decode
  assign opc       = ir[incr_exec_pkg::OPC_HI:incr_exec_pkg::OPC_LO];
  assign is_incr   = !dead && (opc == incr_exec_pkg::OPC_INCR);
  assign is_skz    = !dead && (opc == incr_exec_pkg::OPC_INCR_SKZ);
  assign is_sknz   = !dead && (opc == incr_exec_pkg::OPC_INCR_SKNZ);
  assign is_br     = !dead && (ir[incr_exec_pkg::INSTR_W-1:incr_exec_pkg::BR_OPC_LO] == incr_exec_pkg::OPC_BRANCH);
  assign dest_file = ir[incr_exec_pkg::DEST_BIT];
  assign alu_bus.operand = file_rdata;
  assign file_addr = ir[incr_exec_pkg::DATA_W-1:0];
  // skip decision on incremented value
  assign skip_now  = (is_skz && alu_bus.zero) || (is_sknz && !alu_bus.zero);
  // branch always and a taken skip both cost a dead cycle
  assign next_dead = !dead && (is_br || skip_now);

  // ==================================================
  // sub-phase sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= incr_exec_pkg::Q1;
    end else begin
      case (q)
        incr_exec_pkg::Q1: q <= incr_exec_pkg::Q2;
        incr_exec_pkg::Q2: q <= incr_exec_pkg::Q3;
        incr_exec_pkg::Q3: q <= incr_exec_pkg::Q4;
        default:           q <= incr_exec_pkg::Q1;
      endcase
    end
  end
  assign qphase = q;

  // ==================================================
  // instruction latch and dead-cycle flag, taken at end of Q4
  // the prefetched word is still latched during a dead cycle but never acted on
  always_ff @(posedge clk) begin
    if (srst) begin
      ir   <= incr_exec_pkg::IR_RST;
      dead <= 1'b0;
    end else if (q == incr_exec_pkg::Q4) begin
      ir   <= instr;
      dead <= next_dead;
    end
  end
  assign nop_cycle  = dead;
  assign instr_done = (q == incr_exec_pkg::Q4) && !next_dead;

  // ==================================================
  // file register write at Q4 when dest bit set
  always_ff @(posedge clk) begin
    if (srst) begin
      file_we    <= 1'b0;
      file_wdata <= incr_exec_pkg::WDATA_RST;
    end else begin
      file_we    <= (q == incr_exec_pkg::Q3) && (is_incr || is_skz || is_sknz) && dest_file;
      file_wdata <= alu_bus.result;
    end
  end

  // ==================================================
  // working register write at Q4 when dest bit clear
  // skip forms write here too; a skip drops only the follower
  always_ff @(posedge clk) begin
    if (srst) begin
      working_reg <= incr_exec_pkg::WORK_REG_RST;
    end else if (q == incr_exec_pkg::Q4 && (is_incr || is_skz || is_sknz) && !dest_file) begin
      working_reg <= alu_bus.result;
    end
  end

  // ==================================================
  // status: only plain increment touches flags; skip forms leave them
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= incr_exec_pkg::STATUS_RST;
    end else if (q == incr_exec_pkg::Q4 && is_incr) begin
      status[incr_exec_pkg::ST_CARRY]  <= alu_bus.carry;
      status[incr_exec_pkg::ST_DCARRY] <= alu_bus.dcarry;
      status[incr_exec_pkg::ST_ZERO]   <= alu_bus.zero;
      status[incr_exec_pkg::ST_OVF]    <= alu_bus.ovf;
    end
  end

  // ==================================================
  // program counter: branch target replaces low 13 bits, else step once a cycle
  // page bits above the target field stay put, so a branch cannot leave its page
  // steps also in a dead cycle so the fetch after a skip resumes past the dropped word
  always_ff @(posedge clk) begin
    if (srst) begin
      pc <= incr_exec_pkg::PC_RST;
    end else if (q == incr_exec_pkg::Q4) begin
      if (is_br) begin
        pc <= {pc[incr_exec_pkg::PC_W-1:incr_exec_pkg::BR_TGT_W], ir[incr_exec_pkg::BR_TGT_W-1:0]};
      end else begin
        pc <= pc + 16'h0001;
      end
    end
  end

  // ==================================================
  // checks
  AST_DEST_FILE: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q3 && (is_incr || is_sknz) && dest_file) |=> file_we && file_wdata == $past(file_rdata) + 8'h01)
    else $error("file write of incremented value missing");
  AST_DEST_W: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_incr && !dest_file) |=> working_reg == $past(file_rdata) + 8'h01)
    else $error("working reg not incremented");
  AST_NO_W_ON_FILE: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && dest_file) |=> $stable(working_reg))
    else $error("working reg changed for file destination");
  AST_SKNZ: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_sknz && alu_bus.result != 8'h00) |=> dead [*4])
    else $error("nonzero skip missing");
  AST_SKNZ_NOSKIP: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_sknz && alu_bus.zero) |=> !dead)
    else $error("skip taken on zero result");
  AST_SKZ: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_skz) |=> dead == $past(alu_bus.zero))
    else $error("zero skip mismatch");
  AST_DEAD_ONE: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && dead) |=> !dead)
    else $error("dead cycle longer than one cycle");
  AST_DEAD_NOWRITE: assert property (@(posedge clk) disable iff (srst)
    dead |-> !file_we)
    else $error("write during dead cycle");
  AST_STATUS_KEEP: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && (is_skz || is_sknz)) |=> $stable(status))
    else $error("skip instruction changed status");
  AST_WRAP: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_incr && file_rdata == 8'hFF)
    |=> status[incr_exec_pkg::ST_ZERO] && status[incr_exec_pkg::ST_CARRY])
    else $error("wrap did not set zero and carry");
  AST_BRANCH: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_br) |=> pc[12:0] == $past(ir[12:0]) ##0 dead [*4])
    else $error("branch target or dead cycle wrong");

  // ==================================================
  // checks: writeback of the skip forms and no file write from other cycles
  AST_SKZ_FILE: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q3 && is_skz && dest_file) |=> file_we && file_wdata == $past(file_rdata) + 8'h01)
    else $error("zero-skip file write missing");
  AST_SKNZ_W: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_sknz && !dest_file) |=> working_reg == $past(file_rdata) + 8'h01)
    else $error("nonzero-skip working reg not incremented");
  AST_NO_WRITE_OTHER: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q3 && !(is_incr || is_skz || is_sknz)) |=> !file_we)
    else $error("file write from a non-increment cycle");

  // ==================================================
  // checks: flags of the plain increment
  AST_NOWRAP: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_incr && file_rdata != 8'hFF)
    |=> !status[incr_exec_pkg::ST_ZERO] && !status[incr_exec_pkg::ST_CARRY])
    else $error("zero or carry set without wrap");
  AST_OVF: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_incr) |=> status[incr_exec_pkg::ST_OVF] == ($past(file_rdata) == 8'h7F))
    else $error("overflow flag wrong");

  // ==================================================
  // checks: sequencing, dead cycles and program counter
  AST_QSEQ: assert property (@(posedge clk) disable iff (srst)
    !srst |=> qphase == $past(qphase) + 2'h1)
    else $error("sub-phase did not step");
  AST_PC_STEP: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && !is_br) |=> pc == $past(pc) + 16'h0001)
    else $error("program counter did not step");
  AST_BR_HIGH: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_br) |=> pc[15:13] == $past(pc[15:13]))
    else $error("branch changed page bits");
  AST_NOP_NOACT: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && dead) |=> $stable(working_reg) && $stable(status))
    else $error("dead cycle changed state");
  AST_BR_DONE: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_br) |-> !instr_done ##4 instr_done)
    else $error("branch did not take two cycles");
  AST_SKIP_DONE: assert property (@(posedge clk) disable iff (srst)
    (q == incr_exec_pkg::Q4 && is_sknz && !alu_bus.zero) |-> !instr_done ##4 instr_done)
    else $error("taken skip did not take two cycles");
endmodule

// File: src/incr_exec_pkg.sv
// package of encodings, field positions and counts for the increment/branch executor
// assumes a 16-bit instruction word and an 8-bit data path
package incr_exec_pkg;
  localparam int          DATA_W        = 8;
  localparam int          INSTR_W       = 16;
  localparam int          PC_W          = 16;
  // opcode field positions
  localparam int          OPC_HI        = 15;
  localparam int          OPC_LO        = 9;
  localparam int          DEST_BIT      = 8;
  localparam int          BR_TGT_W      = 13;
  localparam int          BR_OPC_LO     = 13;
  // 7-bit opcodes: nibble plus three bits; 3-bit branch opcode
  localparam logic [6:0]  OPC_INCR      = 7'h0A;  // 0001 010
  localparam logic [6:0]  OPC_INCR_SKZ  = 7'h0F;  // 0001 111
  localparam logic [6:0]  OPC_INCR_SKNZ = 7'h12;  // 0010 010
  localparam logic [2:0]  OPC_BRANCH    = 3'h6;   // 110
  // status bit positions
  localparam int          ST_CARRY      = 0;
  localparam int          ST_DCARRY     = 1;
  localparam int          ST_ZERO       = 2;
  localparam int          ST_OVF        = 3;
  localparam logic [3:0]  STATUS_RST    = 4'h0;
  localparam logic [7:0]  WORK_REG_RST  = 8'h00;
  localparam logic [15:0] IR_RST        = 16'h0000;
  localparam logic [7:0]  WDATA_RST     = 8'h00;
  localparam logic [15:0] PC_RST        = 16'h0000;
  // four sub-phases per instruction cycle
  localparam int          QPHASES       = 4;
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } qphase_t;
endpackage

// File: src/incr_alu_if.sv
// interface carrying operand and result between executor and its incrementer
// assumes one clock domain; purely combinational signals
`timescale 1ns/1ps
interface incr_alu_if;
  logic [7:0] operand;
  logic [7:0] result;
  logic       carry;
  logic       dcarry;
  logic       ovf;
  logic       zero;
  modport ctrl (output operand, input result, carry, dcarry, ovf, zero);
  modport alu  (input operand, output result, carry, dcarry, ovf, zero);
endinterface

// File: src/incr_alu.sv
// incrementer: adds one and derives flags
// assumes a combinational consumer in the same clock domain
`timescale 1ns/1ps
module incr_alu (
  incr_alu_if.alu port_a  // operand in, result and flags out
);
  logic [8:0] sum;
  // ==================================================
  // add one
  // carry out of bit 7 on wrap from all ones
  always_comb begin
    sum            = {1'b0, port_a.operand} + 9'h001;
    port_a.result  = sum[7:0];
    port_a.carry   = sum[8];
    port_a.dcarry  = (port_a.operand[3:0] == 4'hF);
    port_a.ovf     = (port_a.operand == 8'h7F);
    port_a.zero    = (sum[7:0] == 8'h00);
  end
endmodule

// File: bench/tb.sv
// ==========================================================
// testbench for the increment / skip / branch executor
// assumes 10 MHz clk, srst active high, instr taken at Q4 edge
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        srst;
  logic [15:0] instr;
  logic [7:0]  file_rdata;
  logic [7:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [7:0]  working_reg;
  logic [3:0]  status;
  logic [15:0] pc;
  logic [1:0]  qphase;
  logic        nop_cycle;
  logic        instr_done;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [7:0]  ew;
  logic [3:0]  es;

  increment_skip_instr_exec u_increment_skip_instr_exec (
    .clk(clk), .srst(srst), .instr(instr), .file_rdata(file_rdata), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .working_reg(working_reg), .status(status),
    .pc(pc), .qphase(qphase), .nop_cycle(nop_cycle), .instr_done(instr_done));

  // ==========================================================
  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      num_errors++;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected flags {overflow, zero, digit carry, carry} of operand plus one
  function automatic logic [3:0] flags(input logic [7:0] rd);
    flags = {rd == 8'h7F, rd == 8'hFF, rd[3:0] == 4'hF, rd == 8'hFF};
  endfunction

  // one instruction, then a follower that must be dropped after a skip
  task automatic run(input string name, input logic [15:0] v, input logic [7:0] rd,
                     input logic [15:0] nxt, input logic skip);
    logic        upd;
    logic [7:0]  res;
    logic [15:0] p0;
    res = rd + 8'h01;
    upd = (v[15:13] != incr_exec_pkg::OPC_BRANCH);
    do @(negedge clk); while (qphase !== 2'h2);
    @(posedge clk);
    instr      <= v;
    file_rdata <= rd;
    @(posedge clk);
    instr <= nxt;
    do @(negedge clk); while (qphase !== 2'h3);
    chk("file_addr", {8'h00, v[7:0]}, {8'h00, file_addr});
    chk("file_we", {15'h0, upd & v[8]}, {15'h0, file_we});
    if (upd & v[8]) chk("file_wdata", {8'h00, res}, {8'h00, file_wdata});
    chk("instr_done", {15'h0, ~skip}, {15'h0, instr_done});
    p0 = pc;
    @(posedge clk);
    instr <= 16'h0000;
    // expectations move only where the instruction may touch them
    if (upd & !v[8]) ew = res;
    if (v[15:9] == incr_exec_pkg::OPC_INCR) es = flags(rd);
    @(negedge clk);
    chk("working_reg", {8'h00, ew}, {8'h00, working_reg});
    chk("status", {12'h0, es}, {12'h0, status});
    chk("nop_cycle", {15'h0, skip}, {15'h0, nop_cycle});
    if (!upd) chk("pc", {3'h0, v[12:0]}, pc);
    if (upd) chk("pc step", p0 + 16'h0001, pc);
    do @(negedge clk); while (qphase !== 2'h3);
    chk("dropped write", 16'h0000, {15'h0, file_we});
    chk("instr_done after follower", 16'h0001, {15'h0, instr_done});
    $display("test %s done", name);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_incr();
    run("incr wrap to file", {incr_exec_pkg::OPC_INCR, 1'b1, 8'h21}, 8'hFF, 16'h0000, 1'b0);
    run("incr to working", {incr_exec_pkg::OPC_INCR, 1'b0, 8'h22}, 8'h7F, 16'h0000, 1'b0);
  endtask

  task automatic test_skip_nonzero();
    run("sknz taken", {incr_exec_pkg::OPC_INCR_SKNZ, 1'b0, 8'h30}, 8'h12,
        {incr_exec_pkg::OPC_INCR, 1'b1, 8'h55}, 1'b1);
    run("sknz zero", {incr_exec_pkg::OPC_INCR_SKNZ, 1'b1, 8'h31}, 8'hFF, 16'h0000, 1'b0);
  endtask

  task automatic test_skip_zero();
    run("skz taken", {incr_exec_pkg::OPC_INCR_SKZ, 1'b1, 8'h40}, 8'hFF,
        {incr_exec_pkg::OPC_INCR, 1'b1, 8'h66}, 1'b1);
    run("skz nonzero", {incr_exec_pkg::OPC_INCR_SKZ, 1'b0, 8'h41}, 8'h41, 16'h0000, 1'b0);
  endtask

  // mid-run reset: state returns to reset values, sub-phases restart
  task automatic test_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("qphase", 16'h0000, {14'h0, qphase});
    chk("working_reg", {8'h00, incr_exec_pkg::WORK_REG_RST}, {8'h00, working_reg});
    chk("status", {12'h0, incr_exec_pkg::STATUS_RST}, {12'h0, status});
    chk("pc", incr_exec_pkg::PC_RST, pc);
    chk("nop_cycle", 16'h0000, {15'h0, nop_cycle});
    @(negedge clk);
    chk("qphase", 16'h0001, {14'h0, qphase});
    ew = incr_exec_pkg::WORK_REG_RST;
    es = incr_exec_pkg::STATUS_RST;
    $display("test reset done");
  endtask

  task automatic test_branch();
    run("branch", {incr_exec_pkg::OPC_BRANCH, 13'h0123}, 8'h00,
        {incr_exec_pkg::OPC_INCR, 1'b1, 8'h77}, 1'b1);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk        = 1'b0;
    srst       = 1'b1;
    instr      = 16'h0000;
    file_rdata = 8'h00;
    ew         = 8'h00;
    es         = 4'h0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    test_incr();
    test_skip_nonzero();
    test_skip_zero();
    test_reset();
    test_branch();
    end_sim();
  end
endmodule
